/* File: hdl/cbpw_pkg.sv */
/*
  Shared constants for the card bridge power and wake logic: register offsets,
  field positions, reset values, timing and state encodings.
  Assumes a 200 MHz core clock and a classic Wishbone register bus.
*/
package cbpw_pkg;
  localparam int NSOCK = 2;
  localparam int CLK_PERIOD_PS = 5000;
  // Register byte offsets.
  localparam logic [7:0] SYS_CTRL_OFS = 8'h00;
  localparam logic [7:0] SOCK0_CTRL_OFS = 8'h04;
  localparam logic [7:0] MISC_CTRL_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  // System control fields.
  localparam int SYS_MUX_BIT = 0;
  localparam int SYS_HOLD_BIT = 1;
  localparam int SYS_EN_BIT = 24;
  localparam int SYS_PEND_BIT = 25;
  localparam int SYS_ROUTE_BIT = 26;
  // Socket control fields.
  localparam int SK_PWRDN_BIT = 0;
  localparam int SK_MODE_BIT = 1;
  localparam int SK_RING_BIT = 2;
  localparam int SK_MASK_BIT = 3;
  localparam int SK_COE_BIT = 7;
  localparam int SK_PEND_BIT = 16;
  localparam int SK_PWR_LANE = 1;
  // Miscellaneous control fields.
  localparam int MC_RIEN_BIT = 0;
  localparam int MC_POWER_EVENT_ENABLE_BIT = 1;
  localparam int MC_RPIN_BIT = 2;
  localparam int MC_I2PIN_LO = 4;
  localparam int MC_SER_BIT = 6;
  localparam int MC_CSCN_LO = 8;
  localparam int MC_W = 12;
  localparam logic [MC_W-1:0] MISC_RST = 12'h040;
  localparam logic [1:0] I2PIN_3 = 2'h1;
  localparam logic [1:0] I2PIN_6 = 2'h2;
  localparam logic [3:0] IRQ2_SLOT = 4'h2;
  // Serial interrupt frame.
  localparam int SER_ISA_SLOTS = 16;
  localparam int SER_PCI_SLOTS = 4;
  localparam int SER_PHASES = 3;
  // Timing in ns and derived cycle counts.
  localparam int CR_DRIVE_NS = 10;
  localparam int CR_DRIVE_CYC = (CR_DRIVE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CC_IDLE_NS = 640;
  localparam int CC_IDLE_CYC = (CC_IDLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CC_WAIT_NS = 40;
  localparam int CC_WAIT_CYC = (CC_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  typedef enum logic [1:0] {CC_RUN = 2'b00, CC_REQ = 2'b01, CC_STOP = 2'b11} cbpw_cc_type;
  typedef enum logic [1:0] {SQ_IDLE = 2'b00, SQ_START = 2'b01, SQ_SLOT = 2'b11,
                            SQ_STOP = 2'b10} cbpw_sq_type;
endpackage

/* File: hdl/cbpw_top.sv */
/*
  Power and wake logic of a PCI to card bridge: maintenance interrupt, serial
  interrupt frame, PCI clock-run, card clock engine, card power-down, suspend
  gating and ring / power-event pins.
  Assumes pins are asynchronous to CORE_CLK and busy inputs share CORE_CLK.
*/
// The placing of the registers and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
module cbpw_sync #(
  parameter int W = 1
) (
  input wire logic clk, // Clock.
  input wire logic rst_b, // Reset, active low.
  input wire logic [W-1:0] d, // Asynchronous input.
  output logic [W-1:0] q // Synchronised output.
);
  logic [W-1:0] s1_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= '0;
      q <= '0;
    end else begin
      s1_q <= d;
      q <= s1_q;
    end
  end
endmodule

// How it works
// - Enabled maintenance interrupt raised after a socket power-control write.
// - System control holds route bit 26, pending bit 25, enable bit 24.
// - Route bit picks status-change interrupt or IRQ2 delivery.
// - Per-socket pending flag sets on event; software clears it writing one.
// - Status-change route signals per socket, level or edge by mode bit.
// - IRQ2 route in serial mode drives the IRQ2 slot of the frame.
// - Parallel mode IRQ2 output, active low, only on multi pin 3 or 6.
// - Serial frame: start, 16 ISA slots, 4 PCI slots, stop.
// - PCI clock-run handshake lives on multi pin 6.
// - Hold-clock bit refuses every PCI clock stop request.
// - Busy managers, posted data, pending interrupts or running card clocks refuse stop.
// - Card interrupts, status, ring, card clock-run or request restart the clock.
// - Per-socket engine stops the card clock when idle via card clock-run.
// - Output disable tristates and resets card; power-down tristates only when inactive.
// - Suspend blocks both resets and gates the internal clock.
// - Suspend tristates PCI outputs unless a granted transaction is running.
// - Serial interrupt machine runs only on the PCI clock.
// - Ring and multi pins stay active during suspend.
// - Ring output from modem ring, card wake, or card status change.
// - 16-bit ring passes only with ring pass enable set.
// - CardBus wake to ring gated by the status mask bit.
// - With mux bit clear ring and power event share a pin, ring wins.
module cbpw_top (
  input wire logic CORE_CLK, // Core PCI clock, 200 MHz.
  input wire logic RST_B, // Asynchronous reset, active low.
  input wire logic PCI_RST_B, // PCI bus reset pin, active low.
  input wire logic GLB_RST_B, // Global reset pin, active low.
  input wire logic SUSPEND_B, // Suspend pin, active low.
  input wire logic GNT_B, // PCI grant pin, active low.
  input wire logic WB_CYC_I, // Wishbone cycle.
  input wire logic WB_STB_I, // Wishbone strobe.
  input wire logic WB_WE_I, // Wishbone write enable.
  input wire logic [7:0] WB_ADR_I, // Wishbone byte address.
  input wire logic [3:0] WB_SEL_I, // Wishbone byte selects.
  input wire logic [31:0] WB_DAT_I, // Wishbone write data.
  output logic [31:0] WB_DAT_O, // Wishbone read data.
  output logic WB_ACK_O, // Wishbone acknowledge.
  input wire logic RM_BUSY, // 16-bit resource manager busy.
  input wire logic CBM_BUSY, // CardBus master machine busy.
  input wire logic POSTED_BUSY, // PCI master holds posted data.
  input wire logic [1:0] CARD_IS_CB, // Socket holds a CardBus card.
  input wire logic [1:0] CARD_POWERED, // Socket is powered.
  input wire logic [1:0] CARD_ACT, // Card bus activity pin.
  input wire logic [1:0] IREQ_CINT, // Card interrupt pin, active high.
  input wire logic [1:0] STSCHG, // Card status change pin, active high.
  input wire logic [1:0] RING_IN, // 16-bit modem ring pin, active high.
  input wire logic [1:0] CREQ, // CardBus request pin, active high.
  input wire logic [1:0] CCLKRUN_I, // Card clock-run pin level.
  output logic [1:0] CCLKRUN_O, // Card clock-run drive value.
  output logic [1:0] CCLKRUN_OEN, // Card clock-run enable, low drives.
  output logic [1:0] CCLK_EN, // Card clock running.
  output logic [1:0] CARD_HIZ, // 16-bit card interface tristated.
  output logic [1:0] CARD_RESET, // 16-bit card reset.
  output logic [1:0] POWER_STROBE, // Pulse launching a power sequence.
  output logic [15:0] POWER_CODE, // Power switch codes, socket 1 high.
  output logic [1:0] STATUS_CHANGE_IRQ, // Status-change interrupt per socket.
  input wire logic SER_I, // Serial interrupt line level.
  output logic SER_O, // Serial interrupt drive value.
  output logic SER_OEN, // Serial interrupt enable, low drives.
  input wire logic M6_I, // Multi pin 6 level.
  output logic M6_O, // Multi pin 6 drive value.
  output logic M6_OEN, // Multi pin 6 enable, low drives.
  output logic MULTI_PIN_3_B, // IRQ2 output, active low.
  output logic MULTI_PIN_2_B, // Ring output, active low.
  output logic MULTI_PIN_4_B, // Ring output, active low.
  output logic RI_PME_B, // Ring or power-event pin, active low.
  output logic PCI_HIZ, // PCI outputs tristated.
  output logic PCLK_GATED // Internal PCI clock gated.
);
  localparam int NS = cbpw_pkg::NSOCK;
  localparam int NSLOT = cbpw_pkg::SER_ISA_SLOTS + cbpw_pkg::SER_PCI_SLOTS;
  // Our own clock-run drive is still seen through the synchroniser for this many cycles.
  localparam logic [7:0] CC_SETTLE = 8'h02;

  logic [1:0] ireq_s, stschg_s, ring_s, creq_s, cclkrun_s, act_s;
  logic pci_bus_reset_s, global_reset_in_s, susp_s, gnt_s, ser_low_s, m6_s;
  cbpw_sync #(.W(12)) u_sync_card (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .d({IREQ_CINT, STSCHG, RING_IN, CREQ, CCLKRUN_I, CARD_ACT}),
    .q({ireq_s, stschg_s, ring_s, creq_s, cclkrun_s, act_s})
  );
  cbpw_sync #(.W(6)) u_sync_sys (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .d({~PCI_RST_B, ~GLB_RST_B, ~SUSPEND_B, ~GNT_B, ~SER_I, M6_I}),
    .q({pci_bus_reset_s, global_reset_in_s, susp_s, gnt_s, ser_low_s, m6_s})
  );
  // The serial line idles high, so it is synchronised inverted to avoid a false start at reset.
  wire ser_s = ~ser_low_s;

  // Suspend masks both resets and freezes the clocked core.
  wire soft_clr = (pci_bus_reset_s | global_reset_in_s) & ~susp_s;
  // A granted transaction keeps the clock alive until it ends.
  wire gate_on = susp_s & ~gnt_s;
  wire core_en = ~gate_on;

  // Register state.
  logic mux_q, hold_q, en_q, route_q;
  logic [NS-1:0] pend_q;
  logic [15:0] sock_q [NS];
  logic [cbpw_pkg::MC_W-1:0] misc_q;
  logic ack_q;
  logic [31:0] rdat_q;

  wire [31:0] wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  wire req = WB_CYC_I & WB_STB_I & ~ack_q & core_en;
  wire wr = req & WB_WE_I;
  wire [7:0] wadr = {WB_ADR_I[7:2], 2'b00};
  wire sys_hit = wadr == cbpw_pkg::SYS_CTRL_OFS;
  wire misc_hit = wadr == cbpw_pkg::MISC_CTRL_OFS;
  wire stat_hit = wadr == cbpw_pkg::STATUS_OFS;
  wire [31:0] wd = WB_DAT_I & wmask;

  logic [NS-1:0] sock_hit, pwr_wr, pend_clr, pend_set, csc_lvl;
  logic [NS-1:0] hiz_d, rst_d, cc_run, cb_wake, m16_ring;
  logic [31:0] sock_rd [NS];
  genvar gs;
  for (gs = 0; gs < NS; gs++) begin : g_sock
    wire [7:0] ofs = cbpw_pkg::SOCK0_CTRL_OFS + 8'(4 * gs);
    assign sock_hit[gs] = wadr == ofs;
    // Any write into the power-code lane launches a power sequence.
    assign pwr_wr[gs] = wr & sock_hit[gs] & WB_SEL_I[cbpw_pkg::SK_PWR_LANE];
    assign pend_set[gs] = pwr_wr[gs] & en_q;
    assign pend_clr[gs] = wr & ((sys_hit & wd[cbpw_pkg::SYS_PEND_BIT]) |
                                (sock_hit[gs] & wd[cbpw_pkg::SK_PEND_BIT]));
    assign csc_lvl[gs] = en_q & ~route_q & pend_q[gs];
    // Output disable resets and floats; power-down floats an idle card only.
    assign rst_d[gs] = sock_q[gs][cbpw_pkg::SK_COE_BIT];
    assign hiz_d[gs] = rst_d[gs] | (sock_q[gs][cbpw_pkg::SK_PWRDN_BIT] & ~act_s[gs]);
    assign m16_ring[gs] = CARD_POWERED[gs] & ~CARD_IS_CB[gs] & ring_s[gs] &
                          sock_q[gs][cbpw_pkg::SK_RING_BIT];
    assign cb_wake[gs] = CARD_IS_CB[gs] & stschg_s[gs] &
                         sock_q[gs][cbpw_pkg::SK_MASK_BIT];
    assign sock_rd[gs] = {15'h0000, pend_q[gs], sock_q[gs]};

    // Card clock engine: idle count, stop request, then stop unless refused.
    cbpw_pkg::cbpw_cc_type cc_q;
    logic [7:0] idle_q;
    logic oen_q;
    wire busy = act_s[gs] | creq_s[gs] | ~CARD_IS_CB[gs];
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
        cc_q <= cbpw_pkg::CC_RUN;
        idle_q <= 8'h00;
        oen_q <= 1'b1;
      end else begin
        case (cc_q)
          cbpw_pkg::CC_RUN: begin
            oen_q <= 1'b0;
            idle_q <= busy ? 8'h00 : idle_q + 8'h01;
            if (!busy && idle_q == 8'(cbpw_pkg::CC_IDLE_CYC - 1)) begin
              cc_q <= cbpw_pkg::CC_REQ;
              idle_q <= 8'h00;
              oen_q <= 1'b1;
            end
          end
          cbpw_pkg::CC_REQ: begin
            idle_q <= idle_q + 8'h01;
            if (busy || (!cclkrun_s[gs] && idle_q >= CC_SETTLE)) begin
              cc_q <= cbpw_pkg::CC_RUN;
              idle_q <= 8'h00;
            end else if (idle_q == 8'(cbpw_pkg::CC_WAIT_CYC - 1)) begin
              cc_q <= cbpw_pkg::CC_STOP;
            end
          end
          cbpw_pkg::CC_STOP: begin
            idle_q <= 8'h00;
            if (!cclkrun_s[gs] || busy) begin
              cc_q <= cbpw_pkg::CC_RUN;
            end
          end
          default: cc_q <= cbpw_pkg::CC_RUN;
        endcase
      end
    end
    assign cc_run[gs] = cc_q != cbpw_pkg::CC_STOP;
    assign CCLKRUN_O[gs] = 1'b0;
    assign CCLKRUN_OEN[gs] = oen_q;
  end

  // Pending flags: an event in the clearing cycle wins.
  wire [NS-1:0] pend_d = (pend_q & ~pend_clr) | pend_set;
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      {mux_q, hold_q, en_q, route_q} <= 4'h0;
      pend_q <= '0;
      misc_q <= cbpw_pkg::MISC_RST;
      for (int i = 0; i < NS; i++) sock_q[i] <= 16'h0000;
    end else if (soft_clr) begin
      {mux_q, hold_q, en_q, route_q} <= 4'h0;
      pend_q <= '0;
      misc_q <= cbpw_pkg::MISC_RST;
      for (int i = 0; i < NS; i++) sock_q[i] <= 16'h0000;
    end else if (core_en) begin
      pend_q <= pend_d;
      if (wr && sys_hit) begin
        if (WB_SEL_I[0]) begin
          mux_q <= WB_DAT_I[cbpw_pkg::SYS_MUX_BIT];
          hold_q <= WB_DAT_I[cbpw_pkg::SYS_HOLD_BIT];
        end
        if (WB_SEL_I[3]) begin
          en_q <= WB_DAT_I[cbpw_pkg::SYS_EN_BIT];
          route_q <= WB_DAT_I[cbpw_pkg::SYS_ROUTE_BIT];
        end
      end
      if (wr && misc_hit) begin
        misc_q <= (misc_q & ~wmask[cbpw_pkg::MC_W-1:0]) | wd[cbpw_pkg::MC_W-1:0];
      end
      for (int i = 0; i < NS; i++) begin
        if (wr && sock_hit[i]) sock_q[i] <= (sock_q[i] & ~wmask[15:0]) | wd[15:0];
      end
    end
  end

  wire ser_mode = misc_q[cbpw_pkg::MC_SER_BIT];
  wire [1:0] i2pin = misc_q[cbpw_pkg::MC_I2PIN_LO +: 2];
  wire [3:0] csc_num = misc_q[cbpw_pkg::MC_CSCN_LO +: 4];
  wire irq2_on = en_q & route_q & (|pend_q);
  wire csc_any = |csc_lvl;

  // Serial interrupt vector: IRQ2 slot for maintenance, chosen slot for status change.
  logic [NSLOT-1:0] ser_vec;
  genvar gv;
  for (gv = 0; gv < NSLOT; gv++) begin : g_vec
    assign ser_vec[gv] = ser_mode & (((gv == int'(cbpw_pkg::IRQ2_SLOT)) & irq2_on) |
                         ((gv == int'(csc_num)) & csc_any));
  end

  // Clock-stop refusal and restart conditions.
  wire keep_clk = hold_q | RM_BUSY | CBM_BUSY | POSTED_BUSY | (|ser_vec) | csc_any |
                  (|pend_q) | (|cc_run);
  wire restart = (|ireq_s) | (|stschg_s) | (|ring_s) | (|creq_s) | (|(~cclkrun_s & ~cc_run));
  logic [2:0] cr_cnt_q;
  wire cr_drv = cr_cnt_q != 3'h0;
  wire m6_clkrun = i2pin != cbpw_pkg::I2PIN_6;
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cr_cnt_q <= 3'h0;
    end else if (cr_drv) begin
      cr_cnt_q <= cr_cnt_q - 3'h1;
    end else if (m6_clkrun && m6_s && (keep_clk || restart)) begin
      cr_cnt_q <= 3'(cbpw_pkg::CR_DRIVE_CYC);
    end
  end

  // Serial interrupt machine, clocked only while the core clock runs.
  cbpw_pkg::cbpw_sq_type sq_q;
  logic [4:0] slot_q;
  logic [1:0] ph_q;
  logic ser_drv_q, ser_val_q, quiet_q;
  logic [NSLOT-1:0] vec_seen_q;
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sq_q <= cbpw_pkg::SQ_IDLE;
      slot_q <= 5'h00;
      ph_q <= 2'h0;
      ser_drv_q <= 1'b0;
      ser_val_q <= 1'b1;
      vec_seen_q <= '0;
      quiet_q <= 1'b0;
    end else if (core_en) begin
      ser_drv_q <= 1'b0;
      ser_val_q <= 1'b1;
      case (sq_q)
        cbpw_pkg::SQ_IDLE: begin
          quiet_q <= 1'b0;
          if (!ser_s) begin
            sq_q <= cbpw_pkg::SQ_START;
          end else if (ser_vec != vec_seen_q && !quiet_q) begin
            ser_drv_q <= 1'b1; // Ask the host for a frame.
            ser_val_q <= 1'b0;
            quiet_q <= 1'b1;
          end
        end
        cbpw_pkg::SQ_START: begin
          if (ser_s) begin
            sq_q <= cbpw_pkg::SQ_SLOT;
            slot_q <= 5'h00;
            ph_q <= 2'h0;
            vec_seen_q <= ser_vec;
            ser_drv_q <= ser_vec[0];
            ser_val_q <= ~ser_vec[0];
          end
        end
        cbpw_pkg::SQ_SLOT: begin
          // Phase 0 drives the slot low, phase 1 recovers high, phase 2 turns round.
          ser_drv_q <= (ph_q == 2'h0) & vec_seen_q[slot_q];
          if (ph_q == 2'(cbpw_pkg::SER_PHASES - 1)) begin
            ph_q <= 2'h0;
            if (slot_q == 5'(NSLOT - 1)) begin
              sq_q <= cbpw_pkg::SQ_STOP;
            end else begin
              slot_q <= slot_q + 5'h01;
              ser_drv_q <= vec_seen_q[slot_q + 5'h01];
              ser_val_q <= ~vec_seen_q[slot_q + 5'h01];
            end
          end else begin
            ph_q <= ph_q + 2'h1;
          end
        end
        cbpw_pkg::SQ_STOP: begin
          if (!ser_s) begin
            sq_q <= cbpw_pkg::SQ_IDLE;
          end
        end
        default: sq_q <= cbpw_pkg::SQ_IDLE;
      endcase
    end
  end
  assign SER_O = ser_val_q;
  assign SER_OEN = ~ser_drv_q;

  // Ring and power-event pins run even while the core is gated.
  wire ring_src = |(m16_ring | cb_wake);
  wire ring_on = ring_src & misc_q[cbpw_pkg::MC_RIEN_BIT];
  wire pme_on = misc_q[cbpw_pkg::MC_POWER_EVENT_ENABLE_BIT] & (ring_src | (|ireq_s) | (|stschg_s));
  // With the mux clear the shared pin shows ring alone once ring is enabled.
  wire ripme_d = mux_q ? pme_on : (misc_q[cbpw_pkg::MC_RIEN_BIT] ? ring_on : pme_on);
  wire rpin4 = misc_q[cbpw_pkg::MC_RPIN_BIT];
  wire irq2_par = irq2_on & ~ser_mode;

  logic [NS-1:0] csc_prev_q, csc_q, hiz_q, crst_q, strobe_q, cclk_q;
  logic ri_q, m2_q, m4_q, m3_q, m6o_q, m6oen_q, pcihiz_q;
  wire [NS-1:0] csc_d;
  for (gs = 0; gs < NS; gs++) begin : g_csc
    // Level mode follows the flag, edge mode gives one pulse per new event.
    assign csc_d[gs] = sock_q[gs][cbpw_pkg::SK_MODE_BIT] ? (csc_lvl[gs] & ~csc_prev_q[gs])
                                                         : csc_lvl[gs];
  end
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      {csc_prev_q, csc_q, hiz_q, crst_q, strobe_q} <= '0;
      cclk_q <= '1;
      {ri_q, m2_q, m4_q, m3_q, m6o_q, m6oen_q} <= 6'h3f;
      pcihiz_q <= 1'b0;
    end else begin
      csc_prev_q <= csc_lvl;
      csc_q <= csc_d;
      hiz_q <= hiz_d;
      crst_q <= rst_d;
      strobe_q <= pwr_wr;
      cclk_q <= cc_run;
      ri_q <= ~ripme_d;
      m2_q <= ~(mux_q & ~rpin4 & ring_on);
      m4_q <= ~(mux_q & rpin4 & ring_on);
      m3_q <= ~(irq2_par & i2pin == cbpw_pkg::I2PIN_3);
      m6o_q <= m6_clkrun ? 1'b0 : ~irq2_par;
      m6oen_q <= m6_clkrun ? ~cr_drv : 1'b0;
      pcihiz_q <= gate_on;
    end
  end
  assign STATUS_CHANGE_IRQ = csc_q;
  assign CARD_HIZ = hiz_q;
  assign CARD_RESET = crst_q;
  assign POWER_STROBE = strobe_q;
  assign POWER_CODE = {sock_q[1][15:8], sock_q[0][15:8]};
  assign CCLK_EN = cclk_q;
  assign RI_PME_B = ri_q;
  assign MULTI_PIN_2_B = m2_q;
  assign MULTI_PIN_4_B = m4_q;
  assign MULTI_PIN_3_B = m3_q;
  assign M6_O = m6o_q;
  assign M6_OEN = m6oen_q;
  assign PCI_HIZ = pcihiz_q;
  assign PCLK_GATED = pcihiz_q;

  // Register read and acknowledge; unmapped words read zero.
  wire [31:0] sys_rd = {5'h00, route_q, |pend_q, en_q, 22'h000000, hold_q, mux_q};
  wire [31:0] stat_rd = {26'h0000000, keep_clk, hiz_q, cr_drv, cc_run};
  wire [31:0] rd_d = sys_hit ? sys_rd : sock_hit[0] ? sock_rd[0] : sock_hit[1] ? sock_rd[1] :
                     misc_hit ? {20'h00000, misc_q} : stat_hit ? stat_rd : 32'h00000000;
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= req;
      if (req) rdat_q <= rd_d;
    end
  end
  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdat_q;

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  maint_set_a: assert property (pend_set[0] && core_en && !soft_clr |=> pend_q[0])
    else $error("maintenance flag not set after power write");
  pend_keep_a: assert property (pend_q[0] && !pend_clr[0] && !soft_clr |=> pend_q[0])
    else $error("maintenance flag dropped without a clear");
  en_gate_a: assert property (!en_q |=> !csc_q[0] && m3_q)
    else $error("maintenance interrupt delivered while disabled");
  csc_lvl_a: assert property (!sock_q[0][1] && csc_lvl[0] |=> csc_q[0])
    else $error("level status-change output missing");
  irq2_pin_a: assert property (!m3_q |-> $past(i2pin) == cbpw_pkg::I2PIN_3 && $past(route_q))
    else $error("IRQ2 driven on pin 3 without routing");
  keep_clk_a: assert property (hold_q && m6_s && m6_clkrun && !cr_drv |=> ##1 (!M6_OEN) [*2])
    else $error("clock stop not refused while hold bit set");
  coe_a: assert property (rst_d[0] |=> CARD_RESET[0] && CARD_HIZ[0])
    else $error("output disable did not reset and float card");
  susp_a: assert property (susp_s && !gnt_s |=> PCI_HIZ && PCLK_GATED)
    else $error("PCI outputs not floated in suspend");
  ring_a: assert property (ri_q == 1'b0 && !mux_q |-> $past(misc_q[0]) || $past(pme_on))
    else $error("shared pin asserted without a source");
  cc_stop_a: assert property ($fell(cc_run[0]) |-> $past(cclkrun_s[0]))
    else $error("card clock stopped despite refusal");
  pwr_cov_c: cover property (pend_set[0] ##[1:20] pend_clr[0]);
  ser_cov_c: cover property (sq_q == cbpw_pkg::SQ_SLOT && ser_drv_q);
  cc_cov_c: cover property (!cc_run[1] ##[1:50] cc_run[1]);
  susp_cov_c: cover property (gate_on ##1 !gate_on);
endmodule

/* File: verif/cbpw_host.sv */
/*
  Host chipset model on the serial interrupt and clock-run lines.
  Assumes pull-ups on both lines; the device drives low, and drives the serial line high in slot recovery.
*/
`timescale 1ns/1ps
module cbpw_host (
  input wire logic ser_o, // Device serial drive value.
  input wire logic ser_oen, // Device serial enable, low drives.
  input wire logic m6_o, // Device clock-run drive value.
  input wire logic m6_oen, // Device clock-run enable, low drives.
  input wire logic stop_req, // Host asks to stop the clock.
  output logic ser_i, // Resolved serial line.
  output logic m6_i // Resolved clock-run line.
);
  // The host starts no frame, so the pull-up holds the line unless the device drives.
  assign ser_i = ser_oen | ser_o;
  // The host holds clock-run low and releases it to ask for a stop.
  assign m6_i = stop_req ? (m6_oen | m6_o) : 1'b0;
endmodule

/* File: verif/cbpw_top_tb_top.sv */
/*
  Self-checking bench for the power and wake logic.
  Assumes the host model on the shared lines and a 200 MHz clock.
*/
`timescale 1ns/1ps
module cbpw_top_tb_top;
  localparam logic [7:0] SYS = cbpw_pkg::SYS_CTRL_OFS;
  localparam logic [7:0] SK0 = cbpw_pkg::SOCK0_CTRL_OFS;
  localparam logic [7:0] MSC = cbpw_pkg::MISC_CTRL_OFS;
  logic CORE_CLK = 0, RST_B = 0, PCI_RST_B = 1, GLB_RST_B = 1, SUSPEND_B = 1, GNT_B = 1;
  logic WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0, RM_BUSY = 0, CBM_BUSY = 0, POSTED_BUSY = 0;
  logic [7:0] WB_ADR_I = 0, code;
  logic [3:0] WB_SEL_I = 0;
  logic [31:0] WB_DAT_I = 0, WB_DAT_O;
  logic [1:0] CARD_IS_CB = 0, CARD_POWERED = 3, CARD_ACT = 0, IREQ_CINT = 0, STSCHG = 0;
  logic [1:0] RING_IN = 0, CREQ = 0, CCLKRUN_I, CCLKRUN_O, CCLKRUN_OEN, CCLK_EN, CARD_HIZ;
  logic [1:0] CARD_RESET, POWER_STROBE, STATUS_CHANGE_IRQ;
  logic [15:0] POWER_CODE;
  logic WB_ACK_O, SER_I, SER_O, SER_OEN, M6_I, M6_O, M6_OEN, MULTI_PIN_3_B, MULTI_PIN_2_B;
  logic MULTI_PIN_4_B, RI_PME_B, PCI_HIZ, PCLK_GATED, stop_req = 0;
  logic [31:0] q[$];
  int err_count = 0, checks = 0, seed = 72, n, strobes = 0, csc_hi = 0;
  assign CCLKRUN_I = CCLKRUN_OEN | CCLKRUN_O;
  cbpw_top uut (.*);
  cbpw_host host (.ser_o(SER_O), .ser_oen(SER_OEN), .m6_o(M6_O), .m6_oen(M6_OEN),
    .stop_req(stop_req), .ser_i(SER_I), .m6_i(M6_I));
  always #2.5 CORE_CLK = ~CORE_CLK;
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
    input logic [31:0] d, input logic [31:0] e);
    int k;
    k = 0;
    if (!w) q.push_back(e);
    WB_CYC_I <= 1; WB_STB_I <= 1; WB_WE_I <= w; WB_ADR_I <= a; WB_SEL_I <= s; WB_DAT_I <= d;
    do begin
      @(posedge CORE_CLK);
      k++;
    end while (WB_ACK_O !== 1'b1 && k < 50);
    if (k >= 50) err_count++;
    WB_CYC_I <= 0;
    WB_STB_I <= 0;
    @(posedge CORE_CLK);
  endtask
  task automatic settle();
    repeat (6) @(posedge CORE_CLK);
  endtask
  // Read data is compared in the acknowledge cycle, oldest expectation first.
  always @(posedge CORE_CLK) begin
    if (WB_ACK_O === 1'b1 && !WB_WE_I && q.size() > 0) check("rdata", WB_DAT_O, q.pop_front());
    if (POWER_STROBE[0] === 1'b1) strobes++;
    if (STATUS_CHANGE_IRQ[0] === 1'b1) csc_hi++;
  end
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    err_count++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge CORE_CLK);
    RST_B <= 1;
    @(posedge CORE_CLK);
    wb(0, SYS, 4'hf, 0, 32'h0);
    wb(0, MSC, 4'hf, 0, 32'h40);
    wb(0, 8'h20, 4'hf, 0, 32'h0);
    code = 8'($random(seed));
    wb(1, SK0, 4'h2, {16'h0, code, 8'h0}, 0);
    settle();
    check("code", POWER_CODE[7:0], code);
    check("csc off", STATUS_CHANGE_IRQ[0], 0);
    wb(0, SYS, 4'hf, 0, 32'h0);
    wb(1, SYS, 4'hf, 32'h0100_0000, 0);
    wb(1, SK0, 4'h2, {16'h0, code, 8'h0}, 0);
    settle();
    check("csc", STATUS_CHANGE_IRQ[0], 1);
    wb(0, SK0, 4'hf, 0, {15'h0, 1'b1, code, 8'h0});
    wb(0, SYS, 4'hf, 0, 32'h0300_0000);
    wb(1, SK0, 4'h4, 32'h0001_0000, 0);
    settle();
    check("csc clr", STATUS_CHANGE_IRQ[0], 0);
    wb(0, SK0, 4'hf, 0, {16'h0, code, 8'h0});
    n = csc_hi;
    wb(1, SK0, 4'h3, {16'h0, code, 8'h02}, 0);
    settle();
    check("csc edge", csc_hi - n, 1);
    wb(1, MSC, 4'h1, 32'h10, 0);
    wb(1, SYS, 4'hf, 32'h0500_0000, 0);
    wb(1, SK0, 4'h2, {16'h0, code, 8'h0}, 0);
    settle();
    check("irq2", MULTI_PIN_3_B, 0);
    check("csc irq2", STATUS_CHANGE_IRQ[0], 0);
    wb(1, SYS, 4'hf, 32'h0700_0000, 0);
    settle();
    check("irq2 clr", MULTI_PIN_3_B, 1);
    RING_IN <= 2'b01;
    wb(1, MSC, 4'h1, 32'h01, 0);
    settle();
    check("ring off", RI_PME_B, 1);
    wb(1, SK0, 4'h1, 32'h04, 0);
    settle();
    check("ring", RI_PME_B, 0);
    wb(1, SK0, 4'h1, 32'h80, 0);
    settle();
    check("hiz", CARD_HIZ[0], 1);
    check("crst", CARD_RESET[0], 1);
    check("strobes", strobes, 4);
    // Idle CardBus cards lose their clock, which leaves the hold bit as the only refusal.
    RING_IN <= 2'b00;
    CARD_IS_CB <= 2'b11;
    repeat (160) @(posedge CORE_CLK);
    check("cclk", CCLK_EN, 0);
    stop_req <= 1;
    n = 0;
    repeat (20) begin
      @(posedge CORE_CLK);
      if (M6_OEN === 1'b0) n++;
    end
    check("free", n, 0);
    wb(1, SYS, 4'h1, 32'h2, 0);
    n = 0;
    repeat (20) begin
      @(posedge CORE_CLK);
      if (M6_OEN === 1'b0) n++;
    end
    check("hold", n != 0, 1);
    // Grant stays high, so the bus is never parked here across suspend.
    SUSPEND_B <= 0;
    PCI_RST_B <= 0;
    settle();
    check("pci hiz", {PCI_HIZ, PCLK_GATED}, 3);
    PCI_RST_B <= 1;
    settle();
    SUSPEND_B <= 1;
    settle();
    wb(0, SYS, 4'hf, 0, 32'h0500_0002);
    end_of_test();
  end
endmodule
